// File: verilog/crs_defines.svh
// constants for the completer request stream framer
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
`define CRS_DATA_W 512
`define CRS_DW_N 16
`define CRS_SB_W 84
// descriptor field positions
`define CRS_D_CNT_LSB 64
`define CRS_D_TYPE_LSB 75
// request type codes
`define CRS_T_MRD 4'h0
`define CRS_T_MWR 4'h1
`define CRS_T_IOWR 4'h3
// sideband field positions
`define CRS_SB_BE_LSB 0
`define CRS_SB_HEAD_LSB 64
`define CRS_SB_TAIL_LSB 68
`define CRS_SB_SOP 72
`define CRS_SB_TPH 73
`define CRS_SB_TPHT_LSB 74
`define CRS_SB_TAG_LSB 76
// payload start dword in dword-aligned layout
`define CRS_DESC_DW 3'h4
`endif

// File: verilog/crs_pkg.sv
// types for the completer request stream framer
package crs_pkg;
  typedef enum logic [0:0] {
    CRS_IDLE = 1'b0,
    CRS_BODY = 1'b1
  } crs_state_t;
  typedef struct packed {
    logic [511:0] data;
    logic [15:0] keep;
    logic last;
    logic [83:0] sb;
  } crs_beat_t;
endpackage

// File: verilog/crs_framer.sv
// completer request framer onto a 512-bit stream
`timescale 1ns/100ps
`include "crs_defines.svh"
module crs_framer (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic addr_aligned_mode_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [3:0] req_type_i,
  input wire logic [1:0] req_at_i,
  input wire logic [63:2] req_addr_i,
  input wire logic [10:0] req_dw_count_i,
  input wire logic [46:0] req_fields_i,
  input wire logic [3:0] req_head_dword_byte_enables_i,
  input wire logic [3:0] req_tail_be_i,
  input wire logic req_tph_present_i,
  input wire logic [1:0] req_tph_type_i,
  input wire logic [7:0] req_tph_tag_i,
  input wire logic pay_valid_i,
  output logic pay_ready_o,
  input wire logic [511:0] pay_data_i,
  output logic req_stream_valid_o,
  input wire logic req_stream_ready_i,
  output logic [511:0] req_stream_data_o,
  output logic [15:0] req_stream_dword_keep_o,
  output logic req_stream_last_o,
  output logic [83:0] req_stream_sideband_o
);
  // byte enables of one output dword position
  function automatic logic [3:0] dword_be(
    input logic [12:0] g,
    input logic [2:0] s,
    input logic [10:0] cnt,
    input logic [3:0] f,
    input logic [3:0] l
  );
    logic [12:0] i;
    i = g - {10'h000, s};
    if (g < {10'h000, s} || i >= {2'h0, cnt})
      dword_be = 4'h0;
    else if (i == 13'h0000)
      dword_be = f;
    else if (i == {2'h0, cnt} - 13'h0001)
      dword_be = l;
    else
      dword_be = 4'hf;
  endfunction

  // keep mask for dwords still to send
  function automatic logic [15:0] keep_of(input logic [12:0] rem);
    if (rem >= 13'h0010)
      keep_of = 16'hffff;
    else
      keep_of = (16'h0001 << rem[3:0]) - 16'h0001;
  endfunction

  crs_pkg::crs_state_t state;
  logic [2:0] shift_dw;
  logic [10:0] pay_cnt;
  logic [12:0] base;
  logic [4:0] in_left;
  logic [3:0] fbe;
  logic [3:0] lbe;
  logic [511:0] carry;
  crs_pkg::crs_beat_t out_beat;
  crs_pkg::crs_beat_t skid;
  logic skid_valid;
  logic buf_rdy;

  logic idle;
  logic has_pay;
  logic use_in;
  logic need_in;
  logic idle_go;
  logic body_go;
  logic beat_go;
  logic [2:0] in_shift;
  logic [2:0] cur_shift;
  logic [10:0] desc_cnt;
  logic [10:0] in_cnt;
  logic [10:0] cur_cnt;
  logic [12:0] cur_base;
  logic [12:0] cur_rem;
  logic [3:0] cur_fbe;
  logic [3:0] cur_lbe;
  logic [9:0] sh_r;
  logic [127:0] desc;
  logic [511:0] shifted;
  logic [511:0] carried;
  logic [63:0] next_be;
  crs_pkg::crs_beat_t next_beat;

  // buffer accepts a beat only with its spare slot empty
  assign buf_rdy = !skid_valid;
  assign idle = state == crs_pkg::CRS_IDLE;
  assign need_in = in_left != 5'h00;

  // request decode and beat geometry
  always_comb begin
    has_pay = req_type_i == `CRS_T_MWR || req_type_i == `CRS_T_IOWR;
    desc_cnt = req_dw_count_i;
    if (req_type_i == `CRS_T_IOWR)
      desc_cnt = 11'h001;
    in_cnt = has_pay ? desc_cnt : 11'h000;
    in_shift = `CRS_DESC_DW;
    // reads carry no payload, so no gap and keep stays on the descriptor
    if (addr_aligned_mode_i && has_pay)
      in_shift = {1'b1, req_addr_i[3:2]};
    cur_shift = idle ? in_shift : shift_dw;
    cur_cnt = idle ? in_cnt : pay_cnt;
    cur_base = idle ? 13'h0000 : base;
    cur_fbe = idle ? req_head_dword_byte_enables_i : fbe;
    cur_lbe = idle ? req_tail_be_i : lbe;
    cur_rem = {10'h000, cur_shift} + {2'h0, cur_cnt} - cur_base;
    use_in = idle ? has_pay : need_in;
    idle_go = idle && req_valid_i && buf_rdy && (!has_pay || pay_valid_i);
    body_go = !idle && buf_rdy && (!need_in || pay_valid_i);
    beat_go = idle_go || body_go;
  end

  // input handshakes
  assign req_ready_o = idle_go;
  assign pay_ready_o = beat_go && use_in;

  // descriptor: type and count at their fields, reserved bits zero
  assign desc = {1'b0, req_fields_i, 1'b0, req_type_i, desc_cnt,
                 req_addr_i, req_at_i};
  assign sh_r = 10'h200 - {2'h0, cur_shift, 5'h00};

  // payload shifted behind descriptor, carry from previous beat
  always_comb begin
    shifted = 512'h0;
    if (use_in)
      shifted = pay_data_i << {cur_shift, 5'h00};
    carried = idle ? {384'h0, desc} : carry >> sh_r;
  end

  // per-lane byte enables, never on descriptor or gap lanes
  genvar j;
  generate
    for (j = 0; j < `CRS_DW_N; j = j + 1) begin : g_be
      assign next_be[4*j +: 4] = dword_be(cur_base + 13'(j), cur_shift,
                                          cur_cnt, cur_fbe, cur_lbe);
    end
  endgenerate

  // assemble the next beat
  always_comb begin
    next_beat.data = shifted | carried;
    next_beat.keep = keep_of(cur_rem);
    next_beat.last = cur_rem <= 13'h0010;
    next_beat.sb = 84'h0;
    next_beat.sb[`CRS_SB_BE_LSB +: 64] = next_be;
    if (idle) begin
      next_beat.sb[`CRS_SB_SOP] = 1'b1;
      next_beat.sb[`CRS_SB_HEAD_LSB +: 4] = cur_fbe;
      next_beat.sb[`CRS_SB_TAIL_LSB +: 4] = cur_lbe;
      next_beat.sb[`CRS_SB_TPH] = req_tph_present_i;
      if (req_tph_present_i) begin
        next_beat.sb[`CRS_SB_TPHT_LSB +: 2] = req_tph_type_i;
        next_beat.sb[`CRS_SB_TAG_LSB +: 8] = req_tph_tag_i;
      end
    end
  end

  // packet sequencer
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= crs_pkg::CRS_IDLE;
      shift_dw <= `CRS_DESC_DW;
      pay_cnt <= 11'h000;
      base <= 13'h0000;
      in_left <= 5'h00;
      fbe <= 4'h0;
      lbe <= 4'h0;
      carry <= 512'h0;
    end else if (idle_go) begin
      shift_dw <= in_shift;
      pay_cnt <= in_cnt;
      fbe <= req_head_dword_byte_enables_i;
      lbe <= req_tail_be_i;
      carry <= has_pay ? pay_data_i : 512'h0;
      base <= 13'h0010;
      in_left <= 5'h00;
      if (has_pay)
        in_left <= {1'b0, 4'((in_cnt - 11'h001) >> 4)};
      if (!next_beat.last)
        state <= crs_pkg::CRS_BODY;
    end else if (body_go) begin
      if (need_in) begin
        carry <= pay_data_i;
        in_left <= in_left - 5'h01;
      end
      base <= base + 13'h0010;
      if (next_beat.last)
        state <= crs_pkg::CRS_IDLE;
    end
  end

  // two-entry output buffer: output stage plus spare slot
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_beat <= '0;
      skid <= '0;
      skid_valid <= 1'b0;
      req_stream_valid_o <= 1'b0;
    end else if (!req_stream_valid_o || req_stream_ready_i) begin
      if (skid_valid) begin
        out_beat <= skid;
        skid_valid <= 1'b0;
        req_stream_valid_o <= 1'b1;
      end else begin
        req_stream_valid_o <= beat_go;
        if (beat_go)
          out_beat <= next_beat;
      end
    end else if (beat_go) begin
      skid <= next_beat; // stalled: held beat stays put
      skid_valid <= 1'b1;
    end
  end

  assign req_stream_data_o = out_beat.data;
  assign req_stream_dword_keep_o = out_beat.keep;
  assign req_stream_last_o = out_beat.last;
  assign req_stream_sideband_o = out_beat.sb;

  // tracks an open packet on the stream, for checking only
  logic in_pkt;
  logic out_sop;
  logic [3:0] out_type;
  assign out_sop = out_beat.sb[`CRS_SB_SOP];
  assign out_type = out_beat.data[`CRS_D_TYPE_LSB +: 4];
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      in_pkt <= 1'b0;
    else if (req_stream_valid_o && req_stream_ready_i)
      in_pkt <= !req_stream_last_o;
  end

  a_beat_hold: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o && !req_stream_ready_i |=>
      req_stream_valid_o && $stable(out_beat))
    else $error("stalled beat changed");

  a_valid_in_pkt: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    in_pkt |-> req_stream_valid_o)
    else $error("valid dropped inside a packet");

  a_sop_first: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o |-> out_sop == !in_pkt)
    else $error("start flag not on first beat");

  a_keep_contig: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o |-> req_stream_dword_keep_o[0] &&
      ((req_stream_dword_keep_o + 16'h0001) &
       req_stream_dword_keep_o) == 16'h0000)
    else $error("keep bits not contiguous");

  a_keep_mid_full: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o && !req_stream_last_o |->
      req_stream_dword_keep_o == 16'hffff)
    else $error("keep low before last beat");

  a_be_desc_clear: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o && out_sop |->
      req_stream_sideband_o[15:0] == 16'h0000)
    else $error("byte enable on descriptor lane");

  a_read_single: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o && out_sop && out_type == `CRS_T_MRD |->
      req_stream_last_o && req_stream_dword_keep_o == 16'h000f)
    else $error("read not a single descriptor beat");

  a_io_one_dword: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_stream_valid_o && out_sop && out_type == `CRS_T_IOWR |->
      req_stream_last_o &&
      out_beat.data[`CRS_D_CNT_LSB +: 11] == 11'h001 &&
      req_stream_sideband_o[63:32] == 32'h0)
    else $error("io write not one dword");
endmodule

// File: verification/crs_rx_model.sv
// receiver model for the completer request stream
`timescale 1ns/100ps
module crs_rx_model (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic req_stream_valid_i,
  input wire logic [127:0] desc_i,
  input wire logic [83:0] req_stream_sideband_i,
  output logic req_stream_ready_o,
  output logic [12:0] rd_bytes_o,
  output logic [7:0] cpl_data_n_o,
  output logic [7:0] cpl_nodata_n_o
);
  logic [1:0] ph;
  logic first_taken;
  logic [3:0] rq_type;

  // bytes named by a read's dword count and end enables
  function automatic logic [12:0] read_bytes(
    input logic [10:0] c,
    input logic [3:0] h,
    input logic [3:0] t
  );
    logic [3:0] tl;
    logic [12:0] lead;
    logic [12:0] trail;
    tl = (c == 11'h001) ? h : t;
    lead = h[0] ? 13'h0000 : h[1] ? 13'h0001 :
           h[2] ? 13'h0002 : 13'h0003;
    trail = tl[3] ? 13'h0000 : tl[2] ? 13'h0001 :
            tl[1] ? 13'h0002 : 13'h0003;
    read_bytes = {c, 2'h0} - lead - trail;
    if (h == 4'h0)
      read_bytes = 13'h0000; // zero-length read
  endfunction

  // descriptor beat taken, and its request type
  assign first_taken = req_stream_valid_i && req_stream_ready_o &&
                       req_stream_sideband_i[72];
  assign rq_type = desc_i[78:75];

  // one completion owed per read, one data-less per io write
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_bytes_o <= 13'h0000;
      cpl_data_n_o <= 8'h00;
      cpl_nodata_n_o <= 8'h00;
    end else if (first_taken) begin
      if (rq_type == 4'h0) begin
        rd_bytes_o <= read_bytes(desc_i[74:64], req_stream_sideband_i[67:64],
                                 req_stream_sideband_i[71:68]);
        cpl_data_n_o <= cpl_data_n_o + 8'h01;
      end
      if (rq_type == 4'h3)
        cpl_nodata_n_o <= cpl_nodata_n_o + 8'h01;
    end
  end

  // only ready is driven; other start and end flags are ignored
  // stalling keeps ready low three cycles in four
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph <= 2'h0;
      req_stream_ready_o <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      req_stream_ready_o <= !stall_i || (ph == 2'h3);
    end
  end
endmodule

// File: verification/crs_framer_tb.sv
// self-checking bench for the completer request framer
`timescale 1ns/100ps
module crs_framer_tb;
  logic clk = 1'b0, nrst = 1'b0, mode = 1'b0, rv = 1'b0, pv = 1'b0;
  logic stall = 1'b0, tph = 1'b0, hold = 1'b0, inpkt = 1'b0;
  logic [3:0] rt = 4'h0, hb = 4'h0, tb = 4'h0;
  logic [12:0] rdb;
  logic [7:0] ncd, ncn;
  logic [63:2] ra = 62'h0;
  logic [10:0] rc = 11'h0;
  logic [511:0] pd = 512'h0, sd;
  logic rr, pr, sv, sr, sl;
  logic [15:0] sk;
  logic [83:0] ss;
  int n_mismatch = 0, num_checks = 0;
  crs_pkg::crs_beat_t q[$];
  crs_pkg::crs_beat_t pb;
  crs_framer u_dut (
    .core_clk_i(clk), .nrst_i(nrst), .addr_aligned_mode_i(mode),
    .req_valid_i(rv), .req_ready_o(rr), .req_type_i(rt),
    .req_at_i(2'h1), .req_addr_i(ra), .req_dw_count_i(rc),
    .req_fields_i(47'h1234), .req_head_dword_byte_enables_i(hb),
    .req_tail_be_i(tb), .req_tph_present_i(tph), .req_tph_type_i(2'h2),
    .req_tph_tag_i(8'h5a), .pay_valid_i(pv), .pay_ready_o(pr),
    .pay_data_i(pd), .req_stream_valid_o(sv), .req_stream_ready_i(sr),
    .req_stream_data_o(sd), .req_stream_dword_keep_o(sk),
    .req_stream_last_o(sl), .req_stream_sideband_o(ss)
  );
  crs_rx_model u_rx (
    .core_clk_i(clk), .nrst_i(nrst), .stall_i(stall),
    .req_stream_valid_i(sv), .desc_i(sd[127:0]),
    .req_stream_sideband_i(ss), .req_stream_ready_o(sr),
    .rd_bytes_o(rdb), .cpl_data_n_o(ncd), .cpl_nodata_n_o(ncn)
  );
  initial forever #2 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [639:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [511:0] pat(input int b);
    for (int j = 0; j < 16; j++) pat[32*j+:32] = 32'hc0de0000 + 32'(b*16+j);
  endfunction
  // record taken beats, check held beats and valid continuity
  always @(negedge clk) begin
    if (!nrst) begin
      chk("rst valid", sv, 1'b0);
      inpkt = 1'b0;
    end else begin
      if (hold) chk("held", {sv, sd, sk, sl, ss}, {1'b1, pb});
      if (inpkt) chk("valid gap", sv, 1'b1);
      if (sv && sr) begin
        q.push_back({sd, sk, sl, ss});
        inpkt = !sl;
      end
    end
    hold = nrst && sv && !sr;
    pb = {sd, sk, sl, ss};
  end
  // offer one request with nb payload beats, hold until taken
  task automatic send(input logic [3:0] t, input logic [63:2] a,
      input logic [10:0] c, input logic [3:0] h, input int nb);
    int b = 0;
    int w = 0;
    logic tk = 1'b0;
    q.delete();
    rt <= t;
    ra <= a;
    rc <= c;
    hb <= h;
    rv <= 1'b1;
    pv <= nb > 0;
    pd <= pat(0);
    while ((b < nb || !tk) && w < 200) begin
      @(negedge clk);
      tk = tk || (rr === 1'b1);
      b = b + ((pr === 1'b1) ? 1 : 0);
      @(posedge clk);
      rv <= !tk;
      pv <= b < nb;
      pd <= pat(b);
      w++;
    end
    chk("taken", tk, 1'b1);
  endtask
  task automatic got(input int n);
    for (int i = 0; i < 200 && q.size() < n; i++) @(posedge clk);
    chk("beats", q.size(), n);
  endtask
  task automatic beat(input int i, input logic [15:0] k, input logic l,
      input logic [63:0] be);
    chk("keep", q[i].keep, k);
    chk("last", q[i].last, l);
    chk("sop", q[i].sb[72], i == 0);
    chk("lane be", q[i].sb[63:0], be);
  endtask
  // zero-length read with a hint, then a three-dword read
  task automatic t_read();
    tph <= 1'b1;
    send(4'h0, 62'h5, 11'h1, 4'h0, 0);
    tph <= 1'b0;
    got(1);
    beat(0, 16'h000f, 1'b1, 64'h0);
    chk("count", q[0].data[74:64], 11'h1);
    chk("type", q[0].data[78:75], 4'h0);
    chk("ends be", q[0].sb[71:64], 8'h0);
    chk("tph", q[0].sb[83:73], {8'h5a, 2'h2, 1'b1});
    chk("addr", q[0].data[63:2], 62'h5);
    tb <= 4'h3;
    send(4'h0, 62'h9, 11'h3, 4'he, 0);
    tb <= 4'h0;
    got(1);
    beat(0, 16'h000f, 1'b1, 64'h0);
    chk("rd ends", q[0].sb[71:64], 8'h3e);
    @(posedge clk);
    chk("rd bytes", rdb, 13'd9);
    chk("rd cpl", ncd, 8'h2);
  endtask
  // two-beat write under receiver stall
  task automatic t_write();
    logic [511:0] p0 = pat(0);
    logic [511:0] p1 = pat(1);
    stall <= 1'b1;
    tb <= 4'h3;
    send(4'h1, 62'h0, 11'd20, 4'hf, 2);
    tb <= 4'h0;
    got(2);
    stall <= 1'b0;
    beat(0, 16'hffff, 1'b0, 64'hffffffffffff0000);
    beat(1, 16'h00ff, 1'b1, 64'h000000003fffffff);
    chk("type", q[0].data[78:75], 4'h1);
    chk("ends be", q[0].sb[71:64], 8'h3f);
    chk("beat1 head", q[1].sb[83:64], 20'h0);
    chk("pay0", q[0].data[511:128], p0[383:0]);
    chk("pay1", q[1].data[255:0], {p1[127:0], p0[511:384]});
  endtask
  // io write with partial enables, then zero-length write
  task automatic t_io();
    logic [511:0] p = pat(0);
    send(4'h3, 62'h8, 11'd5, 4'h6, 1);
    got(1);
    beat(0, 16'h001f, 1'b1, 64'h60000);
    chk("io count", q[0].data[74:64], 11'h1);
    chk("io type", q[0].data[78:75], 4'h3);
    chk("io pay", q[0].data[159:128], p[31:0]);
    @(posedge clk);
    chk("io cpl", ncn, 8'h1);
    chk("rd cpl", ncd, 8'h2);
    send(4'h1, 62'h0, 11'h1, 4'h0, 1);
    got(1);
    beat(0, 16'h001f, 1'b1, 64'h0);
  endtask
  // aligned layout, every dword position of the second quarter
  task automatic t_align();
    logic [511:0] p = pat(0);
    nrst <= 1'b0;
    mode <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      send(4'h1, 62'(a), 11'h1, 4'hf, 1);
      got(1);
      beat(0, 16'hffff >> (11 - a), 1'b1, 64'hf << (16 + 4 * a));
      chk("al pay", q[0].data[32*(4+a)+:32], p[31:0]);
    end
    send(4'h0, 62'h3, 11'h2, 4'hf, 0);
    got(1);
    beat(0, 16'h000f, 1'b1, 64'h0);
    @(posedge clk);
    chk("al cpl", ncd, 8'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_read();
    t_write();
    t_io();
    t_align();
    report_and_stop();
  end
  initial begin
    #40000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
